// ### hw/conn_teardown.sv
// Connected, disconnect-wait, break-wait and break states of a port
// link layer. Assumes the arbitration machine hands in open_i when a
// link opens, the transmitter takes tx_prim_o and pulses tx_done_i when
// a whole primitive sequence or idle dword has gone, and the receiver
// decodes primitive sequences into rx_i pulses on this clock.
// Contract
// - SMP open enables SMP with hash
// - SSP open enables SSP with hash
// - STP open enables STP only
// - Close request moves to disconnect-wait
// - Close request taken from matching protocol
// - Break request moves to break-wait
// - BREAK while connected reports, enters break
// - Send CLOSE, three idles, start timer
// - Accept peer CLOSE any time in disconnect-wait
// - Both CLOSEs done: report ok, idle
// - Close timeout reports, enters break-wait
// - BREAK in disconnect-wait reports, enters break
// - Send BREAK, three idles, start timer
// - Break-wait ignores all but BREAK, ALIGN; code ignores ALIGN too
// - Break-wait ends on BREAK or link broke
// - Break state sends BREAK then idles
// - Break state ignores all but ALIGN; code ignores ALIGN too, acting only on tx_done_i
// - Open carries protocol and hash
`timescale 1ns/100ps
`include "conn_teardown_consts.svh"
module conn_teardown
   import conn_teardown_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = `TIMEOUT_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire open_ind_t open_i,
   input wire logic ssp_close_req_i,
   input wire logic smp_close_req_i,
   input wire logic stp_close_req_i,
   input wire logic ssp_break_req_i,
   input wire logic smp_break_req_i,
   input wire logic stp_break_req_i,
   input wire rx_prim_t rx_i,
   input wire logic tx_done_i,
   output proto_en_t proto_en_o,
   output tx_prim_t tx_prim_o,
   output logic reason_valid_o,
   output reason_t reason_o,
   output logic idle_o
);

   typedef enum logic [2:0] {
      IDLE_STATE = 3'h0,
      CONNECTED_STATE = 3'h4,
      DISCONNECT_WAIT_STATE = 3'h5,
      BREAK_WAIT_STATE = 3'h6,
      BREAK_STATE = 3'h7
   } state_t;

   typedef enum logic [1:0] {
      PH_SEQ = 2'h0,
      PH_IDLES = 2'h1,
      PH_TIMER = 2'h2
   } phase_t;

   state_t state_reg, state_next;
   phase_t phase_reg, phase_next;
   proto_t proto_reg;
   logic [`HASH_W-1:0] hash_reg;
   logic [1:0] idle_cnt_reg;
   logic [31:0] timer_reg;
   logic close_sent_reg, close_rcvd_reg;
   logic close_req, break_req, timer_exp;
   logic report;
   reason_t report_code;

   always_comb begin
      close_req = 1'b0;
      break_req = 1'b0;
      unique case (proto_reg)
         PROTO_SSP: begin
            close_req = ssp_close_req_i;
            break_req = ssp_break_req_i;
         end
         PROTO_SMP: begin
            close_req = smp_close_req_i;
            break_req = smp_break_req_i;
         end
         PROTO_STP: begin
            close_req = stp_close_req_i;
            break_req = stp_break_req_i;
         end
         PROTO_NONE: begin
            close_req = 1'b0;
            break_req = 1'b0;
         end
      endcase
   end

   // Counter parks at terminal count until the state moves on
   // counter expiry
   assign timer_exp = (phase_reg == PH_TIMER) &&
      (timer_reg == TIMEOUT_CYC - 1);

   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      report = 1'b0;
      report_code = REASON_NONE;
      unique case (state_reg)
         IDLE_STATE: begin
            if (open_i.valid && open_i.proto != PROTO_NONE) begin
               state_next = CONNECTED_STATE;
            end
         end
         CONNECTED_STATE: begin
            // Peer BREAK outranks local requests
            if (rx_i.brk) begin
               report = 1'b1;
               report_code = REASON_BREAK_RCVD;
               state_next = BREAK_STATE;
            end else if (break_req) begin
               state_next = BREAK_WAIT_STATE;
            end else if (close_req) begin
               state_next = DISCONNECT_WAIT_STATE;
            end
         end
         DISCONNECT_WAIT_STATE: begin
            if (rx_i.brk) begin
               report = 1'b1;
               report_code = REASON_BREAK_RCVD;
               state_next = BREAK_STATE;
            end else if (close_sent_reg &&
                         (close_rcvd_reg || rx_i.close)) begin
               report = 1'b1;
               report_code = REASON_NO_ERROR;
               state_next = IDLE_STATE;
            end else if (timer_exp) begin
               report = 1'b1;
               report_code = REASON_CLOSE_TIMEOUT;
               state_next = BREAK_WAIT_STATE;
            end
         end
         BREAK_WAIT_STATE: begin
            if (rx_i.brk) begin
               state_next = IDLE_STATE;
            end else if (timer_exp) begin
               report = 1'b1;
               report_code = REASON_LINK_BROKE;
               state_next = IDLE_STATE;
            end
         end
         BREAK_STATE: begin
            if (tx_done_i) begin
               state_next = IDLE_STATE;
            end
         end
         default: begin
            state_next = IDLE_STATE;
         end
      endcase
      if (state_next != state_reg) begin
         phase_next = PH_SEQ;
      end else if (state_reg == IDLE_STATE ||
                   state_reg == CONNECTED_STATE) begin
         // Nothing to pace here; keeps the timer quiet
         phase_next = PH_SEQ;
      end else if (phase_reg == PH_SEQ && tx_done_i) begin
         phase_next = PH_IDLES;
      end else if (phase_reg == PH_IDLES && tx_done_i &&
                   idle_cnt_reg == 2'(`MIN_IDLE_DWORDS - 1)) begin
         phase_next = PH_TIMER;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= IDLE_STATE;
         phase_reg <= PH_SEQ;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         proto_reg <= PROTO_NONE;
         hash_reg <= '0;
      end else if (state_reg == IDLE_STATE && open_i.valid) begin
         proto_reg <= open_i.proto;
         hash_reg <= (open_i.proto == PROTO_STP) ? '0 : open_i.hash;
      end else if (state_next == IDLE_STATE) begin
         proto_reg <= PROTO_NONE;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idle_cnt_reg <= 2'h0;
         timer_reg <= 32'h0;
      end else begin
         if (phase_reg != PH_IDLES) begin
            idle_cnt_reg <= 2'h0;
         end else if (tx_done_i) begin
            idle_cnt_reg <= idle_cnt_reg + 2'h1;
         end
         if (phase_reg != PH_TIMER || phase_next != PH_TIMER) begin
            timer_reg <= 32'h0;
         end else if (!timer_exp) begin
            timer_reg <= timer_reg + 32'h1;
         end
      end
   end

   // Clean close may end before the idles have gone out
   // peer CLOSE held any time in disconnect-wait
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         close_sent_reg <= 1'b0;
         close_rcvd_reg <= 1'b0;
      end else if (state_reg != DISCONNECT_WAIT_STATE) begin
         close_sent_reg <= 1'b0;
         close_rcvd_reg <= 1'b0;
      end else begin
         if (phase_reg == PH_SEQ && tx_done_i) begin
            close_sent_reg <= 1'b1;
         end
         if (rx_i.close) begin
            close_rcvd_reg <= 1'b1;
         end
      end
   end

   // Built from the next state so enables rise on entry
   // SSP, SMP and STP enables; hash for SSP and SMP, zero for STP
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         proto_en_o <= '0;
      end else begin
         proto_en_o.ssp_en <= state_next == CONNECTED_STATE &&
            (state_reg == IDLE_STATE ? open_i.proto : proto_reg)
            == PROTO_SSP;
         proto_en_o.smp_en <= state_next == CONNECTED_STATE &&
            (state_reg == IDLE_STATE ? open_i.proto : proto_reg)
            == PROTO_SMP;
         proto_en_o.stp_en <= state_next == CONNECTED_STATE &&
            (state_reg == IDLE_STATE ? open_i.proto : proto_reg)
            == PROTO_STP;
         if (state_reg == IDLE_STATE && open_i.valid) begin
            proto_en_o.hash <=
               (open_i.proto == PROTO_STP) ? '0 : open_i.hash;
         end else if (state_next == CONNECTED_STATE) begin
            proto_en_o.hash <= hash_reg;
         end else begin
            proto_en_o.hash <= '0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_prim_o <= TX_IDLE;
      end else if (phase_next != PH_SEQ) begin
         tx_prim_o <= TX_IDLE;
      end else begin
         unique case (state_next)
            DISCONNECT_WAIT_STATE: tx_prim_o <= TX_CLOSE;
            BREAK_WAIT_STATE, BREAK_STATE: tx_prim_o <= TX_BREAK;
            default: tx_prim_o <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reason_valid_o <= 1'b0;
         // Code stays for a late reader until the next report
         reason_o <= REASON_NONE;
         idle_o <= 1'b1;
      end else begin
         reason_valid_o <= report;
         if (report) begin
            reason_o <= report_code;
         end
         idle_o <= state_next == IDLE_STATE;
      end
   end

endmodule : conn_teardown

// ### hw/conn_teardown_consts.svh
// Constants for the connection teardown block.
// Included by the package and the block; definitions only.
`ifndef CONN_TEARDOWN_CONSTS_SVH
`define CONN_TEARDOWN_CONSTS_SVH
`define CLK_FREQ_HZ 125000000
`define TEARDOWN_TIMEOUT_US 1000
`define TIMEOUT_CYCLES ((`CLK_FREQ_HZ / 1000000) * `TEARDOWN_TIMEOUT_US)
`define MIN_IDLE_DWORDS 3
`define HASH_W 24
`endif

// ### hw/conn_teardown_pkg.sv
// Types for the connection teardown block.
// Assumes the constants header is on the include path.
`include "conn_teardown_consts.svh"
package conn_teardown_pkg;
   typedef enum logic [1:0] {
      PROTO_NONE = 2'h0,
      PROTO_SSP = 2'h1,
      PROTO_SMP = 2'h2,
      PROTO_STP = 2'h3
   } proto_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_CLOSE = 3'h1,
      TX_BREAK = 3'h2
   } tx_prim_t;

   typedef enum logic [2:0] {
      REASON_NONE = 3'h0,
      REASON_NO_ERROR = 3'h1,
      REASON_BREAK_RCVD = 3'h2,
      REASON_CLOSE_TIMEOUT = 3'h3,
      REASON_LINK_BROKE = 3'h4
   } reason_t;

   typedef struct packed {
      logic valid;
      proto_t proto;
      logic [`HASH_W-1:0] hash;
   } open_ind_t;

   typedef struct packed {
      logic close;
      logic brk;
      logic align;
   } rx_prim_t;

   typedef struct packed {
      logic ssp_en;
      logic smp_en;
      logic stp_en;
      logic [`HASH_W-1:0] hash;
   } proto_en_t;
endpackage : conn_teardown_pkg

// ### verif/peer_link.sv
// Far-side link model: paces sent items and injects primitives.
// Assumes the bench drives cmd_i and stall_i at the falling edge.
`timescale 1ns/100ps
module peer_link
   import conn_teardown_pkg::*;
(
   input wire logic clk_i,
   input wire logic stall_i,
   input wire rx_prim_t cmd_i,
   output logic done_o,
   output rx_prim_t rx_o
);
   logic [1:0] cnt_reg = 2'h0;
   always_ff @(posedge clk_i) rx_o <= cmd_i;
   // Stall holds a CLOSE or BREAK in flight
   always_ff @(posedge clk_i) begin
      cnt_reg <= cnt_reg + 2'h1;
      done_o <= !stall_i && cnt_reg == 2'h3;
   end
endmodule : peer_link

// ### verif/conn_teardown_chk.sv
// Port checker for the teardown block.
// Bound to it from the bench; one clock domain.
`timescale 1ns/100ps
module conn_teardown_chk
   import conn_teardown_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire open_ind_t open_i,
   input wire logic ssp_close_req_i,
   input wire logic ssp_break_req_i,
   input wire rx_prim_t rx_i,
   input wire logic tx_done_i,
   input wire proto_en_t proto_en_o,
   input wire tx_prim_t tx_prim_o,
   input wire logic reason_valid_o,
   input wire reason_t reason_o,
   input wire logic idle_o
);
   wire conn = proto_en_o.ssp_en | proto_en_o.smp_en | proto_en_o.stp_en;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence opened(proto_t p);
      idle_o && open_i.valid && open_i.proto == p;
   endsequence
   sequence told(reason_t r);
      reason_valid_o && reason_o == r;
   endsequence
   a_ssp_open: assert property (opened(PROTO_SSP) |=>
      proto_en_o.ssp_en && proto_en_o.hash == $past(open_i.hash))
      else $error("ssp enable or hash wrong");
   a_smp_open: assert property (opened(PROTO_SMP) |=>
      proto_en_o.smp_en && proto_en_o.hash == $past(open_i.hash))
      else $error("smp enable or hash wrong");
   a_stp_open: assert property (opened(PROTO_STP) |=>
      proto_en_o.stp_en && proto_en_o.hash == '0)
      else $error("stp enable wrong");
   a_brk_rcvd: assert property (conn && rx_i.brk |=>
      told(REASON_BREAK_RCVD) ##[0:1] tx_prim_o == TX_BREAK)
      else $error("break while connected mishandled");
   a_close_go: assert property (
      proto_en_o.ssp_en && ssp_close_req_i && !ssp_break_req_i
      && !rx_i.brk |-> ##[1:2] tx_prim_o == TX_CLOSE && !conn)
      else $error("close request not taken");
   a_break_go: assert property (
      proto_en_o.ssp_en && ssp_break_req_i && !rx_i.brk
      |-> ##[1:2] tx_prim_o == TX_BREAK && !conn)
      else $error("break request not taken");
   a_break_holds: assert property (
      tx_prim_o == TX_BREAK && !tx_done_i && !rx_i.brk
      |=> tx_prim_o == TX_BREAK)
      else $error("break dropped before sent");
   a_ok_idle: assert property (reason_valid_o &&
      (reason_o == REASON_NO_ERROR || reason_o == REASON_LINK_BROKE)
      |-> idle_o)
      else $error("closure without idle");
   a_timeout_brk: assert property (
      told(REASON_CLOSE_TIMEOUT) |-> ##[0:1] tx_prim_o == TX_BREAK)
      else $error("close timeout without break");
endmodule : conn_teardown_chk

// ### verif/test_conn_teardown.sv
// Self-checking bench for the teardown block.
// Assumes peer_link drives rx_i and tx_done_i.
`timescale 1ns/100ps
module test_conn_teardown;
   import conn_teardown_pkg::*;
   localparam int TOC = 20;
   localparam rx_prim_t CLS = 3'h4;
   localparam rx_prim_t BRK = 3'h2;
   localparam rx_prim_t ALN = 3'h1;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   open_ind_t open_i = '0;
   logic [2:0] cls = '0;
   logic [2:0] brq = '0;
   logic stall = 1'b0;
   rx_prim_t cmd = '0;
   rx_prim_t rx_i;
   logic tx_done_i, reason_valid_o, idle_o;
   proto_en_t proto_en_o, exp_en;
   tx_prim_t tx_prim_o;
   reason_t reason_o;
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   conn_teardown #(.TIMEOUT_CYC(TOC)) DUT (.clk_i, .rst_n_i, .open_i,
      .ssp_close_req_i(cls[0]), .smp_close_req_i(cls[1]),
      .stp_close_req_i(cls[2]), .ssp_break_req_i(brq[0]),
      .smp_break_req_i(brq[1]), .stp_break_req_i(brq[2]), .rx_i,
      .tx_done_i, .proto_en_o, .tx_prim_o, .reason_valid_o, .reason_o,
      .idle_o);
   peer_link P (.clk_i, .stall_i(stall), .cmd_i(cmd), .done_o(tx_done_i),
      .rx_o(rx_i));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rep(output logic [2:0] r);
      r = 3'h7;
      for (int i = 0; i < 200 && r === 3'h7; i++) begin
         @(negedge clk_i);
         if (reason_valid_o === 1'b1) r = reason_o;
      end
   endtask : rep
   task automatic wait_idle();
      for (int i = 0; i < 300 && idle_o !== 1'b1; i++) @(negedge clk_i);
      chk(idle_o, 1'b1);
   endtask : wait_idle
   task automatic send(input rx_prim_t c);
      cmd = c;
      @(negedge clk_i);
      cmd = '0;
   endtask : send
   task automatic ask(input bit b, input int i);
      if (b) brq[i] = 1'b1;
      else cls[i] = 1'b1;
      @(negedge clk_i);
      brq = '0;
      cls = '0;
   endtask : ask
   task automatic open_link(input proto_t p);
      exp_en = {p == PROTO_SSP, p == PROTO_SMP, p == PROTO_STP,
         p == PROTO_STP ? 24'h0 : 24'hA5C31F};
      open_i = {1'b1, p, 24'hA5C31F};
      @(negedge clk_i);
      open_i = '0;
      chk(proto_en_o, exp_en);
   endtask : open_link
   task automatic t_open();
      logic [2:0] r;
      for (int p = 1; p < 4; p++) begin
         open_link(proto_t'(p));
         ask(1'b0, p % 3);
         chk(proto_en_o, exp_en);
         send(BRK);
         rep(r);
         chk(r, REASON_BREAK_RCVD);
         wait_idle();
      end
      $display("t_open done");
   endtask : t_open
   task automatic t_close();
      logic [2:0] r;
      open_link(PROTO_SSP);
      stall = 1'b1;
      ask(1'b0, 0);
      send(CLS);
      chk(tx_prim_o, TX_CLOSE);
      stall = 1'b0;
      rep(r);
      chk(r, REASON_NO_ERROR);
      chk(idle_o, 1'b1);
      $display("t_close done");
   endtask : t_close
   task automatic t_timeout();
      logic [2:0] r;
      open_link(PROTO_SMP);
      ask(1'b0, 1);
      rep(r);
      chk(r, REASON_CLOSE_TIMEOUT);
      chk(tx_prim_o, TX_BREAK);
      send(CLS);
      @(negedge clk_i);
      send(ALN);
      chk(idle_o, 1'b0);
      rep(r);
      chk(r, REASON_LINK_BROKE);
      chk(idle_o, 1'b1);
      $display("t_timeout done");
   endtask : t_timeout
   task automatic t_breaks();
      logic [2:0] r;
      open_link(PROTO_SSP);
      stall = 1'b1;
      ask(1'b1, 0);
      @(negedge clk_i);
      chk(tx_prim_o, TX_BREAK);
      stall = 1'b0;
      send(BRK);
      wait_idle();
      rep(r);
      chk(r, 3'h7);
      open_link(PROTO_SSP);
      stall = 1'b1;
      ask(1'b0, 0);
      send(BRK);
      rep(r);
      chk(r, REASON_BREAK_RCVD);
      send(CLS);
      @(negedge clk_i);
      send(BRK);
      @(negedge clk_i);
      chk(idle_o, 1'b0);
      chk(tx_prim_o, TX_BREAK);
      stall = 1'b0;
      wait_idle();
      $display("t_breaks done");
   endtask : t_breaks
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // Ceiling well above the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(negedge clk_i);
      rst_n_i = 1'b1;
      t_open();
      t_close();
      t_timeout();
      t_breaks();
      print_verdict();
   end
endmodule : test_conn_teardown
bind conn_teardown conn_teardown_chk C (.clk_i, .rst_n_i, .open_i,
   .ssp_close_req_i, .ssp_break_req_i, .rx_i, .tx_done_i, .proto_en_o,
   .tx_prim_o, .reason_valid_o, .reason_o, .idle_o);
